// ### hw/obd_pkg.sv
// Option byte decoder package: addresses, field positions, codes.
package obd_pkg;
  // Flash locations holding the user option bytes
  localparam logic [15:0] OBD_OPT0_ADDR   = 16'h0000;
  localparam logic [15:0] OBD_OPT1_ADDR   = 16'h0001;
  // Field positions within option byte zero
  localparam int          OBD_TOACT_BIT   = 7;
  localparam int          OBD_AON_BIT     = 6;
  localparam int          OBD_BO_HI       = 3;
  localparam int          OBD_BO_LO       = 2;
  localparam int          OBD_RDP_BIT     = 1;
  localparam int          OBD_WRP_BIT     = 0;
  // Brown-out mode codes
  localparam logic [1:0]  OBD_BO_RSVD     = 2'h0;
  localparam logic [1:0]  OBD_BO_OFF      = 2'h1;
  localparam logic [1:0]  OBD_BO_NOSTOP   = 2'h2;
  localparam logic [1:0]  OBD_BO_ALWAYS   = 2'h3;
  // Trim index map
  localparam logic [7:0]  OBD_TRIM_BASE   = 8'h20;
  localparam logic [4:0]  OBD_TRIM_ZERO   = 5'h00;
  localparam logic [4:0]  OBD_TRIM_VREF   = 5'h05;
  localparam logic [4:0]  OBD_TRIM_BGREG  = 5'h06;
  localparam logic [4:0]  OBD_TRIM_WDOSC  = 5'h07;
  localparam logic [4:0]  OBD_TRIM_BIAS   = 5'h0c;
  localparam logic [4:0]  OBD_TRIM_LAST   = 5'h1f;
  localparam logic [7:0]  OBD_TRIM_ZVAL   = 8'h00;
  // Reset values
  localparam logic [7:0]  OBD_ERASED      = 8'hff;
  localparam logic [7:0]  OBD_IDX_RST     = 8'h00;
  localparam int          OBD_TRIM_DEPTH  = 32;
  // Loader sequence states, Gray coded along the load path
  typedef enum logic [2:0] {
    OBD_S_REQ0  = 3'h0,
    OBD_S_WAIT0 = 3'h1,
    OBD_S_REQT  = 3'h3,
    OBD_S_WAITT = 3'h2,
    OBD_S_DONE  = 3'h6
  } obd_state_t;
endpackage

// ### hw/obd_trim_mem.sv
// Working trim value store: 32 bytes, registered read data.
`timescale 1ns/10ps
module obd_trim_mem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock
  input  wire logic          sys_clk,
  // Write side
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [7:0]    wrData,
  // Read side
  input  wire logic [AW-1:0] rdAddr,
  output logic      [7:0]    rdData
);
  // Storage is volatile; contents are lost with power
  logic [7:0] mem [DEPTH];

  // Depth must match the address width, or slots alias or go unreached
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("obd_trim_mem depth must be 2**AW");
  end

  // Synchronous write and registered read
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ### hw/obd_option_byte_decoder.sv
// Option byte loader and decoder with trim index/data port.
// Behaviour
// RULE1: Options come from flash bytes 0000h, 0001h
// RULE2: Action bit 0: time-out raises interrupt
// RULE3: Action bit 1: time-out gives reset
// RULE4: Always-on 0: watchdog runs from power-up
// RULE5: Always-on 1: arm instruction starts watchdog
// RULE6: Brown-out field decodes four documented modes
// RULE7: Read-protect 0 hides code, limits debugger
// RULE8: Write-protect 0 blocks program, page erase
// RULE9: Write-protect 1 allows all erase, programming
// RULE10: Bits 5:4 and byte one ignored
// RULE11: Brown-out field 11 only at power-on
// RULE12: Slot 5 reference trim, slot 7 watchdog
// RULE13: Remaining slots mapped, others reserved
// RULE14: Trim slot zero always reads zero
// RULE15: Latches load on reset before CPU runs
// RULE16: Software resets after changing option bits
// RULE17: Trim index adds fixed 20h offset
// RULE18: Index write, then data write or read
// RULE19: Erased byte gives erased defaults
`timescale 1ns/10ps
module obd_option_byte_decoder
  import obd_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       porEvent,
  input  wire logic       stopRecovery,
  // Flash read port (same clock, one-cycle latency)
  output logic            flashRdReq,
  output logic [15:0]     flashAddr,
  output logic            flashInfo,
  input  wire logic [7:0] flashData,
  // CPU register access to index and data port
  input  wire logic       idxWr,
  input  wire logic       dataWr,
  input  wire logic       dataRd,
  input  wire logic [7:0] cpuWrData,
  output logic [7:0]      trim_index_reg,
  output logic [7:0]      trim_data_port,
  // Watchdog controls
  input  wire logic       wdog_arm_instr,
  input  wire logic       wdogTimeout,
  output logic            wdogIrq,
  output logic            wdogSysReset,
  output logic            wdogRun,
  // Brown-out and protection
  input  wire logic       stopMode,
  output logic            brownoutEn,
  output logic            codeReadable,
  output logic            debugFull,
  output logic            progAllowed,
  output logic            pageEraseAllowed,
  output logic            massEraseAllowed,
  // Sequencing and trim taps
  output logic            cpuRelease,
  output logic [7:0]      vrefTrim,
  output logic [7:0]      wdogOscTrim
);
  // Loader, decode and trim port registers of the block
  typedef struct packed {
    obd_state_t  st;
    logic [7:0]  opt0;     // Option latch, byte zero
    logic [1:0]  boCtl;    // Brown-out field latch
    logic [4:0]  loadIdx;  // Trim copy counter
    logic        loadVld;  // Flash byte arrives this cycle
    logic [7:0]  idx;      // Trim index register
    logic        wdRun;
    logic        rdy;
    logic        irq;
    logic        sysRst;
    logic        boEn;
    logic [7:0]  vref;
    logic [7:0]  wdOsc;
  } obd_regs_t;

  obd_regs_t r_q, r_d;
  logic        memWe;      // Trim store write strobe
  logic [4:0]  memWa;
  logic [7:0]  memWd;
  logic [7:0]  memRd;
  logic        opt0Aon;    // Decoded always-on bit

  // Working trim store
  obd_trim_mem #(.DEPTH(OBD_TRIM_DEPTH), .AW(5)) uMem (
    .sys_clk (sys_clk),
    .wrEn    (memWe),
    .wrAddr  (memWa),
    .wrData  (memWd),
    .rdAddr  (r_q.idx[4:0]),
    .rdData  (memRd)
  );

  assign opt0Aon = r_q.opt0[OBD_AON_BIT];

  // Next-state logic: loader, decode, trim port
  always_comb begin
    r_d     = r_q;
    memWe   = 1'b0;
    memWa   = r_q.idx[4:0];
    memWd   = cpuWrData;
    r_d.loadVld = 1'b0;
    unique case (r_q.st)
      // Fetch option byte zero; byte one is never used
      OBD_S_REQ0: begin // RULE1 RULE10
        r_d.loadVld = 1'b1;
        r_d.st      = OBD_S_WAIT0;
      end
      OBD_S_WAIT0: begin // RULE15
        r_d.opt0 = flashData;
        r_d.st   = OBD_S_REQT;
      end
      // Copy factory trim bytes into working slots 1-31; slot zero gets zero
      OBD_S_REQT: begin
        r_d.loadVld = 1'b1;
        r_d.st      = OBD_S_WAITT;
      end
      OBD_S_WAITT: begin // RULE17
        memWe = 1'b1; // RULE13
        memWa = r_q.loadIdx;
        memWd = (r_q.loadIdx == OBD_TRIM_ZERO) ? OBD_TRIM_ZVAL : flashData;
        if (r_q.loadIdx == OBD_TRIM_VREF) r_d.vref = flashData; // RULE12
        if (r_q.loadIdx == OBD_TRIM_WDOSC) r_d.wdOsc = flashData; // RULE12
        r_d.loadIdx = r_q.loadIdx + 5'h01;
        r_d.st = (r_q.loadIdx == OBD_TRIM_LAST) ? OBD_S_DONE : OBD_S_REQT;
      end
      // CPU released; serve trim port
      OBD_S_DONE: begin
        r_d.rdy = 1'b1; // RULE15
        if (idxWr) r_d.idx = cpuWrData; // RULE18
        if (dataWr && r_q.idx[4:0] != OBD_TRIM_ZERO) begin // RULE14 RULE18
          memWe = 1'b1;
          memWa = r_q.idx[4:0];
          if (r_q.idx[4:0] == OBD_TRIM_VREF) r_d.vref = cpuWrData;
          if (r_q.idx[4:0] == OBD_TRIM_WDOSC) r_d.wdOsc = cpuWrData;
        end
      end
      default: r_d.st = OBD_S_REQ0;
    endcase
    // Field decode applies the erased defaults naturally from 8'hff
    r_d.boCtl = (r_q.st == OBD_S_WAIT0) ? flashData[OBD_BO_HI:OBD_BO_LO] : r_q.boCtl; // RULE19
    // Watchdog enable: forced on, or armed by instruction
    if (r_q.rdy && !opt0Aon) r_d.wdRun = 1'b1; // RULE4
    else if (r_q.rdy && wdog_arm_instr) r_d.wdRun = 1'b1; // RULE5
    // Time-out action selection
    r_d.irq    = r_q.rdy && wdogTimeout && !r_q.opt0[OBD_TOACT_BIT]; // RULE2
    r_d.sysRst = r_q.rdy && wdogTimeout && r_q.opt0[OBD_TOACT_BIT]; // RULE3
    // Brown-out enable per mode
    unique case (r_q.boCtl) // RULE6
      OBD_BO_RSVD, OBD_BO_OFF: r_d.boEn = 1'b0;
      OBD_BO_NOSTOP:           r_d.boEn = !stopMode;
      OBD_BO_ALWAYS:           r_d.boEn = 1'b1;
    endcase
  end

  // State register; reset and stop recovery restart the load
  always_ff @(posedge sys_clk) begin
    if (!rst_n || stopRecovery) begin // RULE15
      r_q.st      <= OBD_S_REQ0;
      r_q.loadIdx <= 5'h00;
      r_q.loadVld <= 1'b0;
      r_q.idx     <= OBD_IDX_RST;
      r_q.wdRun   <= 1'b0;
      r_q.rdy     <= 1'b0;
      r_q.irq     <= 1'b0;
      r_q.sysRst  <= 1'b0;
      r_q.boEn    <= 1'b1;
      r_q.opt0    <= OBD_ERASED;
      r_q.vref    <= r_d.vref;
      r_q.wdOsc   <= r_d.wdOsc;
      // Brown-out field preset only by power-on
      r_q.boCtl   <= porEvent ? OBD_BO_ALWAYS : r_q.boCtl; // RULE11
    end else begin
      r_q <= r_d;
    end
  end

  // Flash address: option byte, then info page 20h..3Fh
  // The request stands in the REQ state; the array answers a cycle after it
  // sees it, so the byte is present during the WAIT state that captures it.
  // Reset and stop recovery hold the byte-zero request, so it is already
  // outstanding in the first cycle of the reload.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || stopRecovery) begin
      flashRdReq <= 1'b1;
      flashAddr  <= OBD_OPT0_ADDR; // RULE1
      flashInfo  <= 1'b0;
    end else begin
      flashRdReq <= (r_d.st == OBD_S_REQ0) || (r_d.st == OBD_S_REQT);
      flashInfo  <= (r_d.st == OBD_S_REQT);
      flashAddr  <= (r_d.st == OBD_S_REQT) ? {11'h000, r_d.loadIdx} + {8'h00, OBD_TRIM_BASE}
                                           : OBD_OPT0_ADDR; // RULE17
    end
  end

  // Outputs registered from state
  always_ff @(posedge sys_clk) begin
    trim_index_reg   <= r_q.idx;
    trim_data_port   <= (r_q.idx[4:0] == OBD_TRIM_ZERO) ? OBD_TRIM_ZVAL : memRd; // RULE14
    wdogIrq          <= r_q.irq;
    wdogSysReset     <= r_q.sysRst;
    wdogRun          <= r_q.wdRun;
    brownoutEn       <= r_q.boEn;
    codeReadable     <= r_q.opt0[OBD_RDP_BIT]; // RULE7
    debugFull        <= r_q.opt0[OBD_RDP_BIT]; // RULE7
    progAllowed      <= r_q.opt0[OBD_WRP_BIT]; // RULE8 RULE9
    pageEraseAllowed <= r_q.opt0[OBD_WRP_BIT]; // RULE8
    massEraseAllowed <= 1'b1; // RULE8 RULE9
    cpuRelease       <= r_q.rdy;
    vrefTrim         <= r_q.vref;
    wdogOscTrim      <= r_q.wdOsc;
  end

  // Checks
  a_wdog_no_stop: assert property (@(posedge sys_clk) disable iff (!rst_n || stopRecovery)
    r_q.wdRun |=> r_q.wdRun) else $error("watchdog stopped while running"); // RULE4
  a_bo_always: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r_q.boCtl == OBD_BO_ALWAYS) |=> r_q.boEn) else $error("brown-out not on"); // RULE6
  a_bo_nostop: assert property (@(posedge sys_clk) disable iff (!rst_n || stopRecovery)
    (r_q.boCtl == OBD_BO_NOSTOP && stopMode) |=> !r_q.boEn) else $error("brown-out in stop"); // RULE6
  a_irq_action: assert property (@(posedge sys_clk) disable iff (!rst_n || stopRecovery)
    (r_q.rdy && wdogTimeout && !r_q.opt0[OBD_TOACT_BIT]) |=> ##1 wdogIrq)
    else $error("no interrupt on time-out"); // RULE2
  a_rst_action: assert property (@(posedge sys_clk) disable iff (!rst_n || stopRecovery)
    (r_q.rdy && wdogTimeout && r_q.opt0[OBD_TOACT_BIT]) |=> ##1 wdogSysReset)
    else $error("no reset on time-out"); // RULE3
  a_slot_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r_q.idx[4:0] == OBD_TRIM_ZERO) |=> (trim_data_port == OBD_TRIM_ZVAL))
    else $error("slot zero not zero"); // RULE14
  a_write_prot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !r_q.opt0[OBD_WRP_BIT] |=> (!progAllowed && massEraseAllowed))
    else $error("write protect wrong"); // RULE8
  a_release_late: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(r_q.rdy) |-> $past(r_q.st) == OBD_S_DONE && r_q.loadIdx == 5'h00)
    else $error("cpu released before load"); // RULE15
endmodule

// ### bench/obd_flash_model.sv
// Flash array model: option bytes and information page, one-cycle read latency.
`timescale 1ns/10ps
module obd_flash_model (
  // Clock
  input  wire logic        sys_clk,
  // Read port from the decoder
  input  wire logic        flashRdReq,
  input  wire logic [15:0] flashAddr,
  input  wire logic        flashInfo,
  output logic      [7:0]  flashData
);
  logic [7:0] optByte  [2];   // Program bytes 0000h and 0001h, loaded by the bench
  logic [7:0] infoByte [32];  // Information locations 20h-3Fh

  initial flashData = 8'h00;

  // Answer the cycle after a request; otherwise show the inverted last byte,
  // so a late sample sees garbage rather than a lucky match
  always @(posedge sys_clk) begin
    if (flashRdReq) begin
      if (flashInfo && flashAddr[15:5] == 11'h001) begin
        flashData <= infoByte[flashAddr[4:0]];
      end else if (!flashInfo && flashAddr[15:1] == 15'h0000) begin
        flashData <= optByte[flashAddr[0]];
      end else begin
        flashData <= 8'h5a;  // Stray address: junk
      end
    end else begin
      flashData <= ~flashData;
    end
  end
endmodule

// ### bench/tb.sv
// Testbench: loads option bytes from a flash model, checks decoded controls and trims.
`timescale 1ns/10ps
module tb;
  import obd_pkg::*;
  // Stimulus
  logic        sys_clk, rst_n, porEvent, stopRecovery, idxWr, dataWr, dataRd;
  logic        wdog_arm_instr, wdogTimeout, stopMode;
  logic [7:0]  cpuWrData;
  // Observed
  logic        flashRdReq, flashInfo, wdogIrq, wdogSysReset, wdogRun, brownoutEn;
  logic        codeReadable, debugFull, progAllowed, pageEraseAllowed, massEraseAllowed;
  logic        cpuRelease;
  logic [15:0] flashAddr;
  logic [7:0]  flashData, trim_index_reg, trim_data_port, vrefTrim, wdogOscTrim;
  // Checking state
  logic        irqSeen, rstSeen;
  logic [7:0]  o, r, s, expQ[$];
  int          selQ[$];
  int          n_fail, total_checks;
  event        look;

  obd_option_byte_decoder uut (.sys_clk, .rst_n, .porEvent, .stopRecovery, .flashRdReq,
    .flashAddr, .flashInfo, .flashData, .idxWr, .dataWr, .dataRd, .cpuWrData,
    .trim_index_reg, .trim_data_port, .wdog_arm_instr, .wdogTimeout, .wdogIrq,
    .wdogSysReset, .wdogRun, .stopMode, .brownoutEn, .codeReadable, .debugFull,
    .progAllowed, .pageEraseAllowed, .massEraseAllowed, .cpuRelease, .vrefTrim,
    .wdogOscTrim);
  obd_flash_model fm (.sys_clk, .flashRdReq, .flashAddr, .flashInfo, .flashData);

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  // Output named by a check selector: flags first, then bytes
  function automatic logic [7:0] obs(int k);
    logic [8:0] f;
    f = {rstSeen, irqSeen, wdogRun, massEraseAllowed, pageEraseAllowed, progAllowed,
         debugFull, codeReadable, brownoutEn};
    case (k)
      9:       return trim_data_port;
      10:      return trim_index_reg;
      11:      return vrefTrim;
      12:      return wdogOscTrim;
      default: return {7'h00, f[k]};
    endcase
  endfunction

  // Takes every note off the queue, oldest first, and compares each with the shown result
  always @(look) begin
    while (expQ.size() > 0) begin
      total_checks++;
      if (obs(selQ[0]) !== expQ[0]) begin
        n_fail++;
        $display("unexpected at %0t: item %0d got %h expected %h", $time, selQ[0],
                 obs(selQ[0]), expQ[0]);
      end
      void'(expQ.pop_front());
      void'(selQ.pop_front());
    end
  end

  // Note an expectation; the result is already settled at the falling edge
  task automatic chk(int k, logic [7:0] e);
    expQ.push_back(e);
    selQ.push_back(k);
    ->look;
    #1;
  endtask

  // Bounded wait for the loader; two more edges for registered outputs
  task automatic wait_rel();
    for (int k = 0; k < 300 && cpuRelease !== 1'b1; k++) @(negedge sys_clk);
    if (cpuRelease !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: release got %h expected %h", $time, cpuRelease, 1'b1);
    end
    repeat (2) @(negedge sys_clk);
  endtask

  // Power-on reset with the given option bytes in flash
  task automatic load(logic [7:0] b0, logic [7:0] b1);
    rst_n = 1'b0;
    porEvent = 1'b1;
    fm.optByte[0] = b0;
    fm.optByte[1] = b1;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    porEvent = 1'b0;
    wait_rel();
  endtask

  // One-cycle strobe on the index/data port: k is {read, data write, index write}
  task automatic acc(logic [2:0] k, logic [7:0] v);
    {dataRd, dataWr, idxWr} = k;
    cpuWrData = v;
    @(negedge sys_clk);
    {dataRd, dataWr, idxWr} = 3'h0;
    repeat (4) @(negedge sys_clk);
  endtask

  // Time-out pulse; pulses are caught over a few edges since their width is free
  task automatic probe();
    irqSeen = 1'b0;
    rstSeen = 1'b0;
    wdogTimeout = 1'b1;
    @(negedge sys_clk);
    wdogTimeout = 1'b0;
    repeat (5) begin
      @(posedge sys_clk);
      #1;
      irqSeen |= wdogIrq;
      rstSeen |= wdogSysReset;
    end
    @(negedge sys_clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard: the tests need well under 2000 cycles
  initial begin
    #240000;
    n_fail++;
    end_sim();
  end

  initial begin
    {sys_clk, stopRecovery, idxWr, dataWr, dataRd, wdog_arm_instr, wdogTimeout} = 7'h00;
    {rst_n, porEvent, stopMode, cpuWrData, n_fail, total_checks} = '0;
    void'($urandom(32'h686a));
    for (int a = 0; a < 32; a++) fm.infoByte[a] = 8'($urandom);
    fm.infoByte[0] = 8'ha5;  // Slot zero must hide this
    // Every brown-out code and both values of each bit, erased byte last
    for (int i = 0; i < 5; i++) begin
      o = 8'($urandom);  // Random reserved bits 5:4
      o[7:6] = i[1:0];
      o[3:2] = i[1:0];
      o[1] = ~i[0];
      o[0] = i[1];
      if (i == 4) o = OBD_ERASED;
      load(o, 8'($urandom));
      chk(0, {7'h00, o[3]});
      stopMode = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk(0, {7'h00, o[3:2] == 2'h3});
      stopMode = 1'b0;
      chk(1, {7'h00, o[1]});
      chk(2, {7'h00, o[1]});
      chk(3, {7'h00, o[0]});
      chk(4, {7'h00, o[0]});
      chk(5, 8'h01);
      chk(6, {7'h00, ~o[6]});
      wdog_arm_instr = 1'b1;
      @(negedge sys_clk);
      wdog_arm_instr = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(6, 8'h01);
      probe();
      chk(7, {7'h00, ~o[7]});
      chk(8, {7'h00, o[7]});
      $display("test options %0d done", i);
    end
    // Stop recovery reloads changed options without power-on
    fm.optByte[0] = 8'hfe;
    stopRecovery = 1'b1;
    @(negedge sys_clk);
    stopRecovery = 1'b0;
    repeat (3) @(negedge sys_clk);
    wait_rel();
    chk(3, 8'h00);
    // Trim port: factory values, read-only slot zero, working writes
    acc(3'h1, 8'h05);
    acc(3'h4, 8'h00);
    chk(9, fm.infoByte[5]);
    chk(11, fm.infoByte[5]);
    chk(12, fm.infoByte[7]);
    acc(3'h1, 8'h00);
    acc(3'h2, 8'h3c);
    chk(9, 8'h00);
    for (int j = 0; j < 2; j++) begin
      s = (j == 0) ? 8'h07 : 8'h1f;
      r = 8'($urandom);
      acc(3'h1, s);
      acc(3'h2, r);
      acc(3'h1, s);
      acc(3'h4, 8'h00);
      chk(9, r);
      chk(10, s);
      if (j == 0) chk(12, r);
    end
    $display("test trim done");
    end_sim();
  end
endmodule
